// ===== config_host_model.sv
// Behavioural serial host that configures the misc control bank
`timescale 1ns/1ps
`include "retimer_misc_defs.svh"

module config_host_model
  import retimer_misc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       dock_mode,
  output reg_access_type  reg_access,
  input  wire logic [7:0] reg_rdata
);
  // ==========================================================
  // Bus idle from time zero
  initial begin
    reg_access = '0;
  end

  // ==========================================================
  // Single byte write, strobe stands for one cycle
  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data, output logic [7:0] sent);
    sent = data;
    // Auto sleep goes off in the same write as the fastest rate
    if (addr == `MISC_A_OFFSET && data[1:0] == 2'b11) begin
      sent[2] = 1'b1;
    end
    // A dock host centres the equalizer high
    if (addr == `MISC_B_OFFSET && dock_mode) begin
      sent[7] = 1'b1;
    end
    @(posedge clk) #1 reg_access = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: sent};
    // Released fields carry the inverse, never a stale copy
    @(posedge clk) #1 reg_access = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~sent};
  endtask

  // ==========================================================
  // Single byte read, data taken once the strobe edge has passed
  task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk) #1 reg_access = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clk) #1 reg_access = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hFF};
    data = reg_rdata;
  endtask
endmodule

// ===== retimer_misc_control_regs.sv
// Misc control register bank of the level-shifting retimer
// Operation
// RULE1: Bit 7 first register swaps input lanes
// RULE2: Bit 6 inverts polarity, retimer mode only
// RULE3: Swap/polarity from strap; locked when source low
// RULE4: Bit 3 forces lowest power down
// RULE5: Bit 2 clear: hot-plug drives power down
// RULE6: Bits 1:0 select port rate, reset 100k
// RULE7: Host sets bit 2 before 400k rate; host model sets it in the same write
// RULE8: Second bit 7 picks source or sink centring
// RULE9: Bit 6 blocks hot-plug forwarding
// RULE10: Bit 5 adaptive equalizer; locked when source low
// RULE11: Bit 4 enables receiver equalizer
// RULE12: Bit 3 aux bridge, large package only
// RULE13: Bit 2 self-clearing commit of staged settings
// RULE14: Idle link applies staged settings without commit
// RULE15: Bits 1:0 select function mode, reset crossover
// RULE16: Host toggles power down after mode change
// RULE17: Host sets sink placement in docks
// RULE18: Reserved bits read zero, writes ignored
// RULE19: Strap fields capture at reset, writable when source high
`timescale 1ns/1ps
`include "retimer_misc_defs.svh"

module retimer_misc_control_regs
  import retimer_misc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  reg_access_type         reg_access,
  output logic [7:0]             reg_rdata,
  input  wire logic              config_source_sel,
  input  wire logic              swap_invert_strap,
  input  wire logic              sink_hotplug_in,
  input  wire logic              output_enable,
  input  wire logic              large_package,
  input  wire logic              rate_above_crossover,
  input  wire logic [13:0]       lane_bits_staged,
  output logic                   source_hotplug_out,
  output logic                   power_down,
  output logic                   lane_swap,
  output logic                   lane_invert,
  output port_rate_type          config_port_rate_sel,
  output logic                   eq_center_sink,
  output logic                   aux_bridge_enable,
  output function_mode_type      function_mode_applied,
  output logic                   retimer_active,
  output lane_settings_type      lane_settings_applied
);

  // ==========================================================
  // Helpers
  // Byte write decode, used for both registers
  function automatic logic write_hit(input reg_access_type acc, input logic [7:0] offs);
    write_hit = acc.wr && (acc.addr == offs);
  endfunction

  // ==========================================================
  // Register storage
  logic              lane_swap_ff;             // Lane order swap
  logic              lane_invert_ff;           // Polarity inversion request
  logic              forced_power_down_ff;     // Host forced sleep
  logic              hotplug_auto_sleep_disable_ff; // Suppress hot-plug sleep
  port_rate_type     rate_ff;                  // Port rate field
  logic              app_sink_ff;              // Placement: 1 is sink
  logic              hotplug_forward_block_ff; // Block hot-plug pass-through
  logic              adaptive_equalizer_sel_ff;// Adaptive versus fixed
  logic              equalizer_enable_ff;      // Receiver equalizer on
  logic              aux_bridge_enable_ff;     // Aux bridge on
  logic [1:0]        mode_ff;                  // Requested function mode
  logic              commit_lane_settings_ff;  // One-cycle commit pulse
  logic              strap_taken_ff;           // Strap caught after release
  function_mode_type mode_applied_ff;          // Mode the lanes run
  lane_settings_type lanes_ff;                 // Settings on the lanes
  logic [7:0]        rdata_ff;                 // Read data flop

  logic              hit_a;                    // Write to first register
  logic              hit_b;                    // Write to second register
  logic              host_owns;                // Serial writes allowed to swap, polarity and adaptive select
  logic              nxt_power_down;           // Combined sleep request
  lane_settings_type staged;                   // Settings waiting to apply
  logic              bypass_commit;            // Link idle, apply freely

  assign hit_a     = write_hit(reg_access, `MISC_A_OFFSET);
  assign hit_b     = write_hit(reg_access, `MISC_B_OFFSET);
  assign host_owns = config_source_sel;

  // ==========================================================
  // Strap capture, done one edge after release so reset loads constants only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_taken_ff <= 1'b0;
    end else begin
      strap_taken_ff <= 1'b1;
    end
  end

  // Swap and polarity: strap at release, pin while pin owns, else host
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lane_swap_ff   <= 1'b0;
      lane_invert_ff <= 1'b0;
    end else if (!strap_taken_ff || !host_owns) begin
      // Pin source keeps the fields tracking the strap
      lane_swap_ff   <= swap_invert_strap; // RULE3 RULE19
      lane_invert_ff <= swap_invert_strap; // RULE3 RULE19
    end else if (hit_a) begin
      lane_swap_ff   <= reg_access.wdata[`A_SWAP_BIT];   // RULE1
      lane_invert_ff <= reg_access.wdata[`A_INVERT_BIT]; // RULE2
    end
  end

  // Power-down controls and port rate, always host writable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      forced_power_down_ff          <= 1'b0;
      hotplug_auto_sleep_disable_ff <= 1'b0;
      rate_ff                       <= port_rate_type'(`RATE_RESET);
    end else if (hit_a) begin
      // Bits 5:4 are dropped here, so reserved writes do nothing
      forced_power_down_ff          <= reg_access.wdata[`A_FORCE_PD_BIT]; // RULE4 RULE18
      hotplug_auto_sleep_disable_ff <= reg_access.wdata[`A_AUTO_DIS_BIT]; // RULE5
      rate_ff <= port_rate_type'(reg_access.wdata[`A_RATE_HI:`A_RATE_LO]); // RULE6
    end
  end

  // Second register plain fields
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      app_sink_ff              <= 1'b0;
      hotplug_forward_block_ff <= 1'b0;
      equalizer_enable_ff      <= `EQ_RESET;
      aux_bridge_enable_ff     <= `AUX_RESET;
      mode_ff                  <= `MODE_RESET;
    end else if (hit_b) begin
      app_sink_ff              <= reg_access.wdata[`B_APP_BIT];   // RULE8
      hotplug_forward_block_ff <= reg_access.wdata[`B_BLOCK_BIT]; // RULE9
      equalizer_enable_ff      <= reg_access.wdata[`B_EQ_BIT];    // RULE11
      aux_bridge_enable_ff     <= reg_access.wdata[`B_AUX_BIT];   // RULE12
      mode_ff                  <= reg_access.wdata[`B_MODE_HI:`B_MODE_LO]; // RULE15
    end
  end

  // Adaptive select ignores serial writes while pins own configuration
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      adaptive_equalizer_sel_ff <= `ADA_RESET;
    end else if (hit_b && host_owns) begin
      adaptive_equalizer_sel_ff <= reg_access.wdata[`B_ADA_BIT]; // RULE10 RULE19
    end
  end

  // Commit bit lives one cycle per commit write; the read port returns zero in its place
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      commit_lane_settings_ff <= 1'b0;
    end else begin
      commit_lane_settings_ff <= hit_b && reg_access.wdata[`B_COMMIT_BIT]; // RULE13
    end
  end

  // ==========================================================
  // Power and hot-plug
  // Host must set auto disable before 400k; not checked here, see RULE7
  assign nxt_power_down = forced_power_down_ff ||
                          (!hotplug_auto_sleep_disable_ff && !sink_hotplug_in); // RULE4 RULE5

  // Registered sleep request and hot-plug pass-through
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_down         <= 1'b0;
      source_hotplug_out <= 1'b0;
    end else begin
      power_down         <= nxt_power_down;
      source_hotplug_out <= sink_hotplug_in && !hotplug_forward_block_ff; // RULE9
    end
  end

  // Mode is adopted only while asleep, so a toggle of sleep brings it in
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_applied_ff <= function_mode_type'(`MODE_RESET);
    end else if (power_down) begin
      mode_applied_ff <= function_mode_type'(mode_ff); // RULE15 RULE16
    end
  end

  // ==========================================================
  // Staged lane settings
  assign staged        = '{equalizer_enable:       equalizer_enable_ff,
                           adaptive_equalizer_sel: adaptive_equalizer_sel_ff,
                           other_lane_bits:        lane_bits_staged};
  assign bypass_commit = !output_enable || !sink_hotplug_in || power_down; // RULE14

  // Lanes take staged values on commit or while the link is idle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lanes_ff <= '{equalizer_enable: `EQ_RESET, adaptive_equalizer_sel: `ADA_RESET,
                    other_lane_bits: 14'h0000};
    end else if (commit_lane_settings_ff || bypass_commit) begin
      lanes_ff <= staged; // RULE13 RULE14
    end
  end

  // ==========================================================
  // Read port, one cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= `BYTE_ZERO;
    end else if (reg_access.rd) begin
      if (reg_access.addr == `MISC_A_OFFSET) begin
        // Reserved bits 5:4 read zero
        rdata_ff <= {lane_swap_ff, lane_invert_ff, 2'b00, forced_power_down_ff,
                     hotplug_auto_sleep_disable_ff, rate_ff}; // RULE18
      end else if (reg_access.addr == `MISC_B_OFFSET) begin
        // Write-only commit bit reads zero
        rdata_ff <= {app_sink_ff, hotplug_forward_block_ff, adaptive_equalizer_sel_ff,
                     equalizer_enable_ff, aux_bridge_enable_ff, 1'b0, mode_ff}; // RULE13
      end else begin
        // Other offsets belong to other banks
        rdata_ff <= `BYTE_ZERO;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata             = rdata_ff;
  assign lane_swap             = lane_swap_ff; // RULE1
  assign retimer_active        = (mode_applied_ff == MODE_RETIMER_FULL) ||
                                 ((mode_applied_ff != MODE_REDRIVER_FULL) && rate_above_crossover);
  assign lane_invert           = lane_invert_ff && retimer_active; // RULE2
  assign config_port_rate_sel  = rate_ff; // RULE6
  assign eq_center_sink        = app_sink_ff; // RULE8 RULE17
  assign aux_bridge_enable     = aux_bridge_enable_ff && large_package; // RULE12
  assign function_mode_applied = mode_applied_ff;
  assign lane_settings_applied = lanes_ff;

  // ==========================================================
  // Assertions
  sequence s_commit_write;
    hit_b && reg_access.wdata[`B_COMMIT_BIT];
  endsequence

  sequence s_commit_done;
    commit_lane_settings_ff ##1 (lanes_ff == $past(staged));
  endsequence

  property p_commit_applies;
    @(posedge clk) disable iff (!reset_n) s_commit_write |=> s_commit_done;
  endproperty
  a_commit_applies: assert property (p_commit_applies) else $error("commit not applied"); // RULE13

  // Pulse must drop on its own unless a fresh commit write follows at once
  property p_commit_clears;
    @(posedge clk) disable iff (!reset_n)
      commit_lane_settings_ff && !(hit_b && reg_access.wdata[`B_COMMIT_BIT]) |=> !commit_lane_settings_ff;
  endproperty
  a_commit_clears: assert property (p_commit_clears) else $error("commit bit stuck"); // RULE13

  property p_staged_hold;
    @(posedge clk) disable iff (!reset_n)
      !commit_lane_settings_ff && !bypass_commit |=> $stable(lanes_ff);
  endproperty
  a_staged_hold: assert property (p_staged_hold) else $error("lanes changed without commit"); // RULE14

  property p_sleep;
    @(posedge clk) disable iff (!reset_n)
      (forced_power_down_ff || (!hotplug_auto_sleep_disable_ff && !sink_hotplug_in)) |=> power_down;
  endproperty
  a_sleep: assert property (p_sleep) else $error("power down missing"); // RULE4

  property p_awake;
    @(posedge clk) disable iff (!reset_n)
      !forced_power_down_ff && hotplug_auto_sleep_disable_ff |=> !power_down;
  endproperty
  a_awake: assert property (p_awake) else $error("auto sleep not suppressed"); // RULE5

  property p_forward;
    @(posedge clk) disable iff (!reset_n)
      source_hotplug_out |-> $past(sink_hotplug_in) && !$past(hotplug_forward_block_ff);
  endproperty
  a_forward: assert property (p_forward) else $error("hot-plug forwarding wrong"); // RULE9

  property p_pin_lock;
    @(posedge clk) disable iff (!reset_n)
      strap_taken_ff && !host_owns |=> lane_swap_ff == $past(swap_invert_strap)
                                      && $stable(adaptive_equalizer_sel_ff);
  endproperty
  a_pin_lock: assert property (p_pin_lock) else $error("serial write taken while pins own"); // RULE3

  property p_reserved_zero;
    @(posedge clk) disable iff (!reset_n)
      $past(reg_access.rd) && $past(reg_access.addr) == `MISC_A_OFFSET |-> reg_rdata[5:4] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero"); // RULE18

  property p_invert_mode;
    @(posedge clk) disable iff (!reset_n) lane_invert |-> retimer_active && lane_invert_ff;
  endproperty
  a_invert_mode: assert property (p_invert_mode) else $error("inversion outside retimer mode"); // RULE2

  property p_aux;
    @(posedge clk) disable iff (!reset_n) aux_bridge_enable |-> large_package;
  endproperty
  a_aux: assert property (p_aux) else $error("aux bridge on small package"); // RULE12

endmodule

// ===== retimer_misc_control_regs_test.sv
// Self-checking bench for the misc control register bank
`timescale 1ns/1ps
`include "retimer_misc_defs.svh"

module retimer_misc_control_regs_test
  import retimer_misc_pkg::*;
;
  // ==========================================================
  // Design signals
  logic              clk, reset_n, config_source_sel, swap_invert_strap, sink_hotplug_in, dock_mode;
  logic              output_enable, large_package, rate_above_crossover;
  logic              source_hotplug_out, power_down, lane_swap, lane_invert, eq_center_sink;
  logic              aux_bridge_enable, retimer_active;
  logic [13:0]       lane_bits_staged;
  logic [7:0]        reg_rdata;
  reg_access_type    reg_access;
  port_rate_type     config_port_rate_sel;
  function_mode_type function_mode_applied;
  lane_settings_type lane_settings_applied;
  // Reference model state
  logic              m_swap, m_inv, m_pd, m_ad, m_app, m_blk, m_ada, m_eq, m_aux;
  logic [1:0]        m_rate, m_mode, m_appl;
  logic [15:0]       m_lane;
  logic [31:0]       seed = 32'h4b0b_fd91;
  int                err_count = 0, compares = 0, cycles = 0;

  retimer_misc_control_regs retimer_misc_control_regs_i (.clk(clk), .reset_n(reset_n), .reg_access(reg_access),
    .reg_rdata(reg_rdata), .config_source_sel(config_source_sel), .swap_invert_strap(swap_invert_strap),
    .sink_hotplug_in(sink_hotplug_in), .output_enable(output_enable), .large_package(large_package),
    .rate_above_crossover(rate_above_crossover), .lane_bits_staged(lane_bits_staged),
    .source_hotplug_out(source_hotplug_out), .power_down(power_down), .lane_swap(lane_swap),
    .lane_invert(lane_invert), .config_port_rate_sel(config_port_rate_sel), .eq_center_sink(eq_center_sink),
    .aux_bridge_enable(aux_bridge_enable), .function_mode_applied(function_mode_applied),
    .retimer_active(retimer_active), .lane_settings_applied(lane_settings_applied));
  config_host_model config_host_model_i (.clk(clk), .dock_mode(dock_mode), .reg_access(reg_access),
    .reg_rdata(reg_rdata));

  // ==========================================================
  // Model helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] exp_a();
    return {m_swap, m_inv, 2'b00, m_pd, m_ad, m_rate};
  endfunction
  function automatic logic [7:0] exp_b();
    return {m_app, m_blk, m_ada, m_eq, m_aux, 1'b0, m_mode};
  endfunction
  function automatic logic exp_pd();
    return m_pd | (!m_ad & !sink_hotplug_in);
  endfunction
  function automatic logic idle();
    return !output_enable | !sink_hotplug_in | exp_pd();
  endfunction

  // Let registered outputs land
  task automatic settle();
    repeat (4) @(posedge clk) #1;
  endtask
  // Strap tracking, mode apply and idle lane copy after inputs settle
  task automatic follow();
    if (!config_source_sel) {m_swap, m_inv} = {2{swap_invert_strap}};
    if (exp_pd()) m_appl = m_mode;
    if (idle()) m_lane = {m_eq, m_ada, lane_bits_staged};
  endtask

  // ==========================================================
  // Comparisons
  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_pins();
    logic ra;
    ra = (m_appl == 2'b11) | ((m_appl == 2'b01 || m_appl == 2'b10) & rate_above_crossover);
    report({5'b0, source_hotplug_out, power_down, lane_swap, lane_invert, config_port_rate_sel, eq_center_sink,
            aux_bridge_enable, function_mode_applied, retimer_active, lane_settings_applied},
           {5'b0, sink_hotplug_in & !m_blk, exp_pd(), m_swap, m_inv & ra, m_rate, m_app,
            m_aux & large_package, m_appl, ra, m_lane});
  endtask
  task automatic check_read(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    config_host_model_i.read_byte(addr, got);
    report({24'h00_0000, got}, {24'h00_0000, exp});
  endtask

  // Write through the host and mirror it in the model
  task automatic do_write(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] sent;
    logic       pd_old, idle_old, commit;
    pd_old = exp_pd();
    idle_old = idle();
    commit = 1'b0;
    config_host_model_i.write_byte(addr, data, sent);
    if (addr == `MISC_A_OFFSET) begin
      if (config_source_sel) {m_swap, m_inv} = sent[7:6];
      {m_pd, m_ad, m_rate} = sent[3:0];
    end
    if (addr == `MISC_B_OFFSET) begin
      {m_app, m_blk} = sent[7:6];
      if (config_source_sel) m_ada = sent[5];
      {m_eq, m_aux, commit, m_mode} = sent[4:0];
    end
    // Power down still high on the edge after the write
    if (pd_old) m_appl = m_mode;
    settle();
    if (commit | idle_old) m_lane = {m_eq, m_ada, lane_bits_staged};
    follow();
  endtask

  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      err_count++;
      print_verdict();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [7:0]  addr;
    logic [1:0]  mode_old;
    logic [7:0]  orig;
    reset_n = 1'b0;
    {config_source_sel, swap_invert_strap, sink_hotplug_in, output_enable} = 4'hF;
    {large_package, rate_above_crossover, dock_mode} = 3'b110;
    lane_bits_staged = 14'h0000;
    // Strap high after release loads swap and invert
    {m_swap, m_inv, m_pd, m_ad, m_rate, m_app, m_blk, m_ada, m_eq, m_aux} = 11'h647;
    m_rate = 2'b10;
    m_mode = 2'b01;
    m_appl = 2'b01;
    m_lane = {2'b11, 14'h0000};
    repeat (3) @(posedge clk);
    #1 reset_n = 1'b1;
    settle();
    check_pins();
    check_read(`MISC_A_OFFSET, exp_a());
    check_read(`MISC_B_OFFSET, exp_b());
    check_read(8'h0B, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 80; i++) begin
      r = xs();
      {config_source_sel, swap_invert_strap, sink_hotplug_in} = {r[0] | r[1], r[2], r[3] | r[4]};
      {output_enable, large_package, rate_above_crossover, dock_mode} = {r[5] | r[6], r[7], r[8], r[9] & r[10]};
      settle();
      follow();
      check_pins();
      lane_bits_staged = r[23:10];
      settle();
      follow();
      check_pins();
      r = xs();
      addr = (r[9:8] == 2'b11) ? 8'h0B : (r[8] ? `MISC_B_OFFSET : `MISC_A_OFFSET);
      mode_old = m_mode;
      do_write(addr, r[7:0]);
      // Mode change needs a power down pulse to apply
      if (addr == `MISC_B_OFFSET && m_mode != mode_old) begin
        orig = exp_a();
        do_write(`MISC_A_OFFSET, orig ^ 8'h08);
        do_write(`MISC_A_OFFSET, orig);
      end
      check_pins();
      check_read(`MISC_A_OFFSET, exp_a());
      check_read(`MISC_B_OFFSET, exp_b());
      check_read(8'h0B, 8'h00);
    end
    $display("test random done");
    print_verdict();
  end
endmodule

// ===== retimer_misc_defs.svh
// Offsets, field positions and reset values of the misc control registers
`ifndef RETIMER_MISC_DEFS_SVH
`define RETIMER_MISC_DEFS_SVH

// ==========================================================
// Register offsets
`define MISC_A_OFFSET      8'h09
`define MISC_B_OFFSET      8'h0A

// ==========================================================
// First register field positions
`define A_SWAP_BIT         7
`define A_INVERT_BIT       6
`define A_FORCE_PD_BIT     3
`define A_AUTO_DIS_BIT     2
`define A_RATE_HI          1
`define A_RATE_LO          0

// ==========================================================
// Second register field positions
`define B_APP_BIT          7
`define B_BLOCK_BIT        6
`define B_ADA_BIT          5
`define B_EQ_BIT           4
`define B_AUX_BIT          3
`define B_COMMIT_BIT       2
`define B_MODE_HI          1
`define B_MODE_LO          0

// ==========================================================
// Reset values
`define RATE_RESET         2'b10
`define MODE_RESET         2'b01
`define ADA_RESET          1'b1
`define EQ_RESET           1'b1
`define AUX_RESET          1'b1
`define BYTE_ZERO          8'h00

`endif

// ===== retimer_misc_pkg.sv
// Types shared by the misc control register bank
package retimer_misc_pkg;

  // ==========================================================
  // Function mode encodings
  typedef enum logic [1:0] {
    MODE_REDRIVER_FULL = 2'b00,
    MODE_AUTO_CROSS    = 2'b01,
    MODE_AUTO_RETIMER  = 2'b10,
    MODE_RETIMER_FULL  = 2'b11
  } function_mode_type;

  // Configuration port rate encodings
  typedef enum logic [1:0] {
    RATE_5K   = 2'b00,
    RATE_10K  = 2'b01,
    RATE_100K = 2'b10,
    RATE_400K = 2'b11
  } port_rate_type;

  // Lane settings that reach the lanes on commit or while the link is idle
  typedef struct packed {
    logic        equalizer_enable;
    logic        adaptive_equalizer_sel;
    logic [13:0] other_lane_bits;
  } lane_settings_type;

  // Byte access from the serial front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_type;

endpackage
